/* File: rtl/usx_pkg.sv */
// package for the serial transmit and synchronous mode unit
package usx_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] ADDR_MODE_ONE = 3'h0;
    localparam logic [2:0] ADDR_MODE_TWO = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_TX_DATA = 3'h3;
    localparam logic [2:0] ADDR_RX_DATA = 3'h4;
    localparam logic [2:0] ADDR_PRESCALE = 3'h5;
    localparam logic [2:0] ADDR_DIVISOR = 3'h6;
    // mode control one fields
    localparam int MODE_SELECT_POS = 0;
    localparam int CLOCK_SOURCE_POS = 1;
    localparam int CHAR_LOW_POS = 2;
    localparam int CHAR_HIGH_POS = 3;
    localparam int STOP_LENGTH_POS = 4;
    localparam int PARITY_POL_POS = 5;
    localparam int PARITY_EN_POS = 6;
    localparam int BIT_ORDER_POS = 7;
    // mode control two fields
    localparam int EMPTY_IRQ_EN_POS = 0;
    localparam int DONE_IRQ_EN_POS = 1;
    localparam int RX_IRQ_EN_POS = 2;
    localparam int TX_ENABLE_POS = 3;
    localparam int RX_ENABLE_POS = 4;
    localparam int TX_OUT_EN_POS = 6;
    localparam int CLK_OUT_EN_POS = 7;
    // status fields
    localparam int TX_EMPTY_POS = 0;
    localparam int TX_DONE_POS = 1;
    localparam int RX_FULL_POS = 2;
    localparam int OVERRUN_POS = 4;
    // reset values
    localparam logic [7:0] MODE_ONE_RESET = 8'h00;
    localparam logic [7:0] MODE_TWO_RESET = 8'h00;
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    localparam logic [7:0] DIVISOR_RESET = 8'h02;
    // async bit time is four baud ticks
    localparam logic [1:0] ASYNC_TICKS_LAST = 2'h3;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_SHIFT = 2'b10,
        TX_STOP = 2'b11
    } usx_state_type;

    typedef struct packed {
        logic bit_order;
        logic parity_en;
        logic parity_pol;
        logic stop_two;
        logic [1:0] char_len;
        logic clk_ext;
        logic sync_mode;
    } usx_mode_one_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usx_bus_type;
endpackage

/* File: rtl/usx_top.sv */
// serial transmitter with asynchronous frame and synchronous clocked modes
// Contract
// - async transmit uses order, parity, polarity, stop, length, clock from mode one; async ignores the clock bit and uses the baud generator
// - transmission starts whether enable is set before or after the data write
// - writing the transmit data register clears the buffer empty flag; the code leaves it set when the write meets a move in the same cycle
// - moving data into the shift register sets the buffer empty flag
// - with buffer interrupt enabled, empty flag high raises transmit interrupt
// - done-enable set and empty-enable clear: end of frame sets done and interrupts
// - back to back, both flags set where the last frame bit ends
// - async transmit and receive run independently and may overlap; the code has no async receive and receives in synchronous mode only
// - mode select one picks synchronous mode, zero picks asynchronous
// - synchronous character length selectable five to eight bits
// - synchronous mode sends no parity and no stop bit
// - synchronous shift clock is baud generator or external clock
// - clock output enable low makes clock pin input; high drives baud divided by two
// - synchronous divisor accepts 01h to FFh, 00h meaning 256
// - internal clock runs only while transmitting; receive-only needs dummy write
// - external clock with receive enabled samples data on each rising edge
// - async frame: low start, data in chosen order, high stop, idle high
// - async stop one or two bits, five to eight data bits
// - parity enable switches parity bit, polarity chooses its sense
// - async bit rate is baud generator output divided by four
//
// Implementation choices: the register offsets and the address-and-strobe port.
module usx_top (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial lines
    output logic ser_out,
    input wire logic ser_in,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    // interrupt requests of the unit
    output logic tx_irq,
    output logic rx_irq
);
    usx_pkg::usx_bus_type bus;
    usx_pkg::usx_mode_one_type mode;
    usx_pkg::usx_state_type state_q, state_d;
    logic [7:0] mode_one_q, mode_two_q, tdata_q, rdata_q, shift_q, rshift_q, rd_q;
    logic [7:0] div_q, div_cnt_q;
    logic [1:0] pre_q;
    logic [2:0] pre_cnt_q;
    logic empty_q, done_q, full_q, over_q, loaded_q;
    logic [1:0] tick_cnt_q;
    logic [3:0] bit_cnt_q, rbit_cnt_q;
    logic parity_q, sclk_q, out_q, cur_bit;
    logic [1:0] stop_cnt_q;
    logic ext_q, ext_prev_q;
    logic tx_en, rx_en, clk_out_en, sync_mode, baud_tick, bit_tick, step;
    logic ext_rise, ext_fall, int_fall, int_rise, sh_fall, sh_rise;
    logic wr_data, wr_mode_two, rd_rx, start_load, data_last;
    logic [3:0] nbits;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign mode = usx_pkg::usx_mode_one_type'(mode_one_q);
    assign sync_mode = mode.sync_mode;
    assign tx_en = mode_two_q[usx_pkg::TX_ENABLE_POS];
    assign rx_en = mode_two_q[usx_pkg::RX_ENABLE_POS];
    assign clk_out_en = mode_two_q[usx_pkg::CLK_OUT_EN_POS];
    assign wr_data = bus.wr && (bus.addr == usx_pkg::ADDR_TX_DATA);
    assign wr_mode_two = bus.wr && (bus.addr == usx_pkg::ADDR_MODE_TWO);
    assign rd_rx = bus.rd && (bus.addr == usx_pkg::ADDR_RX_DATA);
    assign nbits = 4'h5 + {2'h0, mode.char_len};

    // baud generator: prescale 1/2/4/8, then divisor where zero counts 256
    assign baud_tick = (pre_cnt_q == 3'h0) && (div_cnt_q == 8'h01 || (div_q == 8'h01));
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 8'h01; // first tick soon after reset, not 256 steps later
        end else begin
            pre_cnt_q <= (pre_cnt_q == 3'h0) ? 3'((4'h1 << pre_q) - 4'h1) : pre_cnt_q - 3'h1;
            if (pre_cnt_q == 3'h0) begin
                div_cnt_q <= (div_cnt_q == 8'h01) ? div_q : div_cnt_q - 8'h01;
            end
        end
    end

    // external clock edges; pin taken as synchronous
    assign ext_rise = ext_q && !ext_prev_q;
    assign ext_fall = !ext_q && ext_prev_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_q <= 1'b1;
            ext_prev_q <= 1'b1;
        end else begin
            ext_q <= serial_clock_pin_i;
            ext_prev_q <= ext_q;
        end
    end

    // internal shift clock toggles on baud ticks only while a frame shifts
    assign int_fall = baud_tick && sclk_q && (state_q == usx_pkg::TX_SHIFT);
    assign int_rise = baud_tick && !sclk_q;
    assign sh_fall = mode.clk_ext ? ext_fall : int_fall;
    assign sh_rise = mode.clk_ext ? ext_rise : int_rise;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_q <= 1'b1;
        end else if (!sync_mode || state_q != usx_pkg::TX_SHIFT) begin
            sclk_q <= 1'b1;
        end else if (baud_tick) begin
            sclk_q <= !sclk_q;
        end
    end
    assign serial_clock_pin_o = sclk_q;
    assign serial_clock_pin_oe = clk_out_en && sync_mode;

    // async bit time of four baud ticks
    assign bit_tick = baud_tick && (tick_cnt_q == usx_pkg::ASYNC_TICKS_LAST);
    assign step = sync_mode ? sh_fall : bit_tick;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_q <= 2'h0;
        end else if (state_q == usx_pkg::TX_IDLE) begin
            tick_cnt_q <= 2'h0;
        end else if (baud_tick) begin
            tick_cnt_q <= tick_cnt_q + 2'h1;
        end
    end

    // transmit state machine
    assign start_load = (state_q == usx_pkg::TX_IDLE) && tx_en && loaded_q;
    assign data_last = (bit_cnt_q == nbits - 4'h1);
    // bit now leaving the shifter: msb-first data sits right-aligned in shift_q
    assign cur_bit = mode.bit_order ? shift_q[3'(nbits - 4'h1)] : shift_q[7];
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            usx_pkg::TX_IDLE: if (start_load) state_d = sync_mode ? usx_pkg::TX_SHIFT : usx_pkg::TX_START;
            usx_pkg::TX_START: if (step) state_d = usx_pkg::TX_SHIFT;
            usx_pkg::TX_SHIFT: if (step && data_last) begin
                state_d = sync_mode ? usx_pkg::TX_IDLE : usx_pkg::TX_STOP;
            end
            usx_pkg::TX_STOP: if (step && stop_cnt_q == 2'h1) state_d = usx_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= usx_pkg::TX_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            stop_cnt_q <= 1'b0;
            parity_q <= 1'b0;
            out_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (start_load) begin
                shift_q <= mode.bit_order ? tdata_q : {<<{tdata_q}};
                bit_cnt_q <= 4'h0;
                parity_q <= mode.parity_pol;
                // stop steps count the parity slot too, so the frame ends after the last stop bit
                stop_cnt_q <= 2'h1 + 2'(mode.stop_two) + 2'(mode.parity_en);
                out_q <= sync_mode ? out_q : 1'b0;
            end else if (state_q == usx_pkg::TX_IDLE) begin
                // async idles high; sync keeps its last data bit
                out_q <= sync_mode ? out_q : 1'b1;
            end else if (step) begin
                unique case (state_q)
                    usx_pkg::TX_IDLE: out_q <= 1'b1;
                    usx_pkg::TX_START, usx_pkg::TX_SHIFT: begin
                        if (state_q == usx_pkg::TX_SHIFT && data_last) begin
                            out_q <= sync_mode ? cur_bit : (mode.parity_en ? parity_q : 1'b1);
                        end else begin
                            out_q <= cur_bit;
                            shift_q <= {shift_q[6:0], 1'b0};
                            parity_q <= parity_q ^ cur_bit;
                            bit_cnt_q <= (state_q == usx_pkg::TX_SHIFT) ? bit_cnt_q + 4'h1 : bit_cnt_q;
                        end
                    end
                    usx_pkg::TX_STOP: begin
                        out_q <= 1'b1;
                        stop_cnt_q <= stop_cnt_q - 2'h1;
                    end
                endcase
            end
        end
    end
    assign ser_out = out_q;

    // buffer and completion flags
    logic frame_end;
    assign frame_end = (state_q != usx_pkg::TX_IDLE) && (state_d == usx_pkg::TX_IDLE);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            empty_q <= 1'b1;
            done_q <= 1'b0;
            loaded_q <= 1'b0;
            tdata_q <= 8'h00;
        end else begin
            if (wr_data) begin
                tdata_q <= bus.wdata;
                loaded_q <= 1'b1;
            end else if (start_load) begin
                loaded_q <= 1'b0;
            end
            // set wins: a write in the same cycle as a move leaves the empty flag set
            if (start_load) begin
                empty_q <= 1'b1;
            end else if (wr_data) begin
                empty_q <= 1'b0;
            end
            if (frame_end && !loaded_q) begin
                done_q <= 1'b1;
            end else if (wr_data) begin
                done_q <= 1'b0;
            end
        end
    end
    assign tx_irq = (mode_two_q[usx_pkg::EMPTY_IRQ_EN_POS] && empty_q)
                  || (mode_two_q[usx_pkg::DONE_IRQ_EN_POS] && done_q);

    // synchronous receive on shift clock rising edges; with the internal clock only while a frame shifts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rshift_q <= 8'h00;
            rbit_cnt_q <= 4'h0;
            rdata_q <= 8'h00;
            full_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            if (!rx_en || !sync_mode) begin
                rbit_cnt_q <= 4'h0;
            end else if (sh_rise && (mode.clk_ext || state_q == usx_pkg::TX_SHIFT)) begin
                rshift_q <= {ser_in, rshift_q[7:1]};
                rbit_cnt_q <= (rbit_cnt_q == nbits - 4'h1) ? 4'h0 : rbit_cnt_q + 4'h1;
            end
            if (sync_mode && rx_en && sh_rise && rbit_cnt_q == nbits - 4'h1) begin
                if (full_q) begin
                    over_q <= 1'b1;
                end else begin
                    rdata_q <= {ser_in, rshift_q[7:1]} >> (4'h8 - nbits);
                    full_q <= 1'b1;
                end
            end else if (rd_rx) begin
                full_q <= 1'b0;
            end
        end
    end
    assign rx_irq = mode_two_q[usx_pkg::RX_IRQ_EN_POS] && full_q;

    // register writes and one-cycle-late reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_one_q <= usx_pkg::MODE_ONE_RESET;
            mode_two_q <= usx_pkg::MODE_TWO_RESET;
            pre_q <= usx_pkg::PRESCALE_RESET;
            div_q <= usx_pkg::DIVISOR_RESET;
        end else if (bus.wr) begin
            if (bus.addr == usx_pkg::ADDR_MODE_ONE) mode_one_q <= bus.wdata;
            if (wr_mode_two) mode_two_q <= bus.wdata;
            if (bus.addr == usx_pkg::ADDR_PRESCALE) pre_q <= bus.wdata[1:0];
            if (bus.addr == usx_pkg::ADDR_DIVISOR) div_q <= bus.wdata;
        end
    end

    logic [7:0] rd_mux;
    assign rd_mux = (bus.addr == usx_pkg::ADDR_MODE_ONE) ? mode_one_q
                  : (bus.addr == usx_pkg::ADDR_MODE_TWO) ? mode_two_q
                  : (bus.addr == usx_pkg::ADDR_STATUS) ? {3'h0, over_q, 1'b0, full_q, done_q, empty_q}
                  : (bus.addr == usx_pkg::ADDR_RX_DATA) ? rdata_q
                  : (bus.addr == usx_pkg::ADDR_PRESCALE) ? {6'h00, pre_q}
                  : (bus.addr == usx_pkg::ADDR_DIVISOR) ? div_q
                  : 8'h00;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= bus.rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rd_q;

    // checks
    write_clears_a: assert property (@(posedge clk) disable iff (!resetn)
        (wr_data && !start_load) |=> !empty_q) else $error("empty flag not cleared by data write");
    move_sets_a: assert property (@(posedge clk) disable iff (!resetn)
        start_load |=> empty_q && !loaded_q) else $error("empty flag not set on move");
    empty_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode_two_q[usx_pkg::EMPTY_IRQ_EN_POS] && empty_q) |-> tx_irq) else $error("missing empty irq");
    done_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        (frame_end && !loaded_q) |=> done_q) else $error("done flag not set at frame end");
    idle_high_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == usx_pkg::TX_IDLE && !start_load && !sync_mode) |=> ser_out) else $error("line not idle high");
    start_low_a: assert property (@(posedge clk) disable iff (!resetn)
        (start_load && !sync_mode) |=> !ser_out) else $error("start bit not low");
    sync_no_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        sync_mode |-> state_q != usx_pkg::TX_STOP && state_q != usx_pkg::TX_START) else $error("framing in sync");
    clk_pin_a: assert property (@(posedge clk) disable iff (!resetn)
        serial_clock_pin_oe == (clk_out_en && sync_mode)) else $error("clock pin direction wrong");
    clk_idle_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == usx_pkg::TX_IDLE) |=> serial_clock_pin_o) else $error("clock runs without transmit");
    mode_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        (start_load && sync_mode) |=> state_q == usx_pkg::TX_SHIFT) else $error("sync start wrong");
    stop_end_a: assert property (@(posedge clk) disable iff (!resetn)
        (frame_end && !sync_mode) |-> ser_out) else $error("frame ended off a stop bit");
endmodule

/* File: tb/usx_peer.sv */
// remote serial peer that decodes asynchronous frames sent by the unit
module usx_peer (
    // clock
    input wire logic clk,
    // line and frame settings
    input wire logic line,
    input wire logic [7:0] cfg,
    input wire logic [15:0] bclks,
    // decoded frame
    output logic got,
    output logic [9:0] frame,
    // receive line towards the unit
    output logic ser_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] d;
    logic p;
    logic s;
    int n;
    // nobody receives here, so the line never rests on one level
    always @(posedge clk) begin
        ser_in <= ~ser_in;
    end
    initial begin
        got = 1'b0;
        frame = 10'h000;
        ser_in = 1'b1;
        forever begin
            @(negedge line);
            // synchronous traffic is not framed, so it is ignored here
            if (!cfg[0]) begin
                repeat (bclks / 2) @(posedge clk);
                n = 5 + cfg[3:2];
                d = 8'h00;
                p = 1'b0;
                for (int i = 0; i < n; i++) begin
                    repeat (bclks) @(posedge clk);
                    if (cfg[7]) begin
                        d = {d[6:0], line};
                    end else begin
                        d[i] = line;
                    end
                end
                if (cfg[6]) begin
                    repeat (bclks) @(posedge clk);
                    p = line;
                end
                repeat (bclks) @(posedge clk);
                s = line;
                if (cfg[4]) begin
                    repeat (bclks) @(posedge clk);
                    s = s & line;
                end
                frame <= {s, p, d};
                got <= 1'b1;
                @(posedge clk);
                got <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/tb.sv */
// self-checking testbench for the serial transmit and synchronous mode unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ser_out, ser_in, pin_o, pin_oe, tx_irq, rx_irq, got;
    logic rd_d = 1'b0;
    logic [9:0] frame;
    logic [7:0] m1 = 8'h00;
    logic [15:0] bclks = 16'h0008;
    logic [15:0] rq[$];
    logic [15:0] fq[$];
    int err_total = 0;
    int checks = 0;
    wire logic pin_level;

    always #12.5 clk = ~clk;
    // clock pin is pulled high whenever the unit leaves it
    assign pin_level = pin_oe ? pin_o : 1'b1;

    usx_top usx_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_out(ser_out), .ser_in(ser_in),
        .serial_clock_pin_i(pin_level), .serial_clock_pin_o(pin_o), .serial_clock_pin_oe(pin_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq));
    usx_peer usx_peer_i (.clk(clk), .line(ser_out), .cfg(m1), .bclks(bclks), .got(got), .frame(frame),
        .ser_in(ser_in));

    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) chk({8'h00, reg_rdata}, rq.pop_front());
        rd_d <= reg_rd;
        if (got) chk({6'h00, frame}, fq.pop_front());
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rq.push_back({8'h00, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_got();
        int k;
        k = 0;
        while (got !== 1'b1 && k < 20000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 20000) begin
            err_total++;
            stop_test();
        end
        @(posedge clk);
    endtask

    // unused upper data bits are not sent, parity covers the sent bits only
    function automatic logic [15:0] exp_frame(input logic [7:0] m, input logic [7:0] d);
        logic [7:0] md;
        md = d & (8'hff >> (3 - m[3:2]));
        return {6'h00, 1'b1, m[6] & (m[5] ^ (^md)), md};
    endfunction

    task automatic async_run(input int i);
        logic [7:0] d0, d1, m2, dv;
        logic [1:0] ps;
        ps = 2'($urandom_range(1, 0));
        dv = 8'($urandom_range(5, 2));
        m2 = i[2] ? 8'h0a : 8'h09;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        wr(usx_pkg::ADDR_MODE_TWO, 8'h00);
        m1 <= (8'($urandom) & 8'hf0) | {4'h0, i[1:0], 2'b00};
        bclks <= 16'(4 * (1 << ps) * dv);
        @(posedge clk);
        wr(usx_pkg::ADDR_MODE_ONE, m1);
        wr(usx_pkg::ADDR_PRESCALE, {6'h00, ps});
        wr(usx_pkg::ADDR_DIVISOR, dv);
        if (i[0]) begin
            wr(usx_pkg::ADDR_TX_DATA, d0);
            rd(usx_pkg::ADDR_STATUS, 8'h00);
            wr(usx_pkg::ADDR_MODE_TWO, m2);
        end else begin
            wr(usx_pkg::ADDR_MODE_TWO, m2);
            wr(usx_pkg::ADDR_TX_DATA, d0);
        end
        fq.push_back(exp_frame(m1, d0));
        rd(usx_pkg::ADDR_STATUS, 8'h01);
        chk({15'h0000, tx_irq}, {15'h0000, ~m2[1]});
        if (i >= 4) begin
            wr(usx_pkg::ADDR_TX_DATA, d1);
            fq.push_back(exp_frame(m1, d1));
            rd(usx_pkg::ADDR_STATUS, 8'h00);
            chk({15'h0000, tx_irq}, 16'h0000);
            wait_got();
            repeat (bclks + 2) @(posedge clk);
            rd(usx_pkg::ADDR_STATUS, 8'h01);
        end
        wait_got();
        repeat (bclks + 2) @(posedge clk);
        rd(usx_pkg::ADDR_STATUS, 8'h03);
        chk({15'h0000, tx_irq}, 16'h0001);
    endtask

    task automatic sync_run(input logic [7:0] dv, input logic [1:0] cl);
        int k, n, t0, t1;
        logic last;
        wr(usx_pkg::ADDR_MODE_TWO, 8'h00);
        m1 <= {4'h0, cl, 2'b01};
        @(posedge clk);
        wr(usx_pkg::ADDR_MODE_ONE, m1);
        wr(usx_pkg::ADDR_PRESCALE, 8'h00);
        wr(usx_pkg::ADDR_DIVISOR, dv);
        wr(usx_pkg::ADDR_MODE_TWO, 8'h88);
        repeat (20) @(posedge clk);
        chk({14'h0000, pin_oe, pin_level}, 16'h0003);
        wr(usx_pkg::ADDR_TX_DATA, 8'($urandom));
        n = 0;
        t0 = 0;
        t1 = 0;
        last = pin_level;
        // fixed observation window covers the slowest transfer in the table
        for (k = 0; k < 12000; k++) begin
            @(posedge clk);
            if (pin_level && !last) begin
                n++;
                if (n == 1) t0 = k;
                if (n == 2) t1 = k;
            end
            last = pin_level;
        end
        chk(16'(n), 16'(5 + cl));
        chk(16'(t1 - t0), 16'(2 * (dv == 8'h00 ? 256 : dv)));
        rd(usx_pkg::ADDR_STATUS, 8'h03);
    endtask

    initial begin
        void'($urandom(57825));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(usx_pkg::ADDR_MODE_ONE, usx_pkg::MODE_ONE_RESET);
        rd(usx_pkg::ADDR_MODE_TWO, usx_pkg::MODE_TWO_RESET);
        rd(usx_pkg::ADDR_STATUS, 8'h01);
        rd(usx_pkg::ADDR_PRESCALE, {6'h00, usx_pkg::PRESCALE_RESET});
        rd(usx_pkg::ADDR_DIVISOR, usx_pkg::DIVISOR_RESET);
        rd(usx_pkg::ADDR_TX_DATA, 8'h00);
        rd(3'h7, 8'h00);
        wr(usx_pkg::ADDR_STATUS, 8'hfe);
        rd(usx_pkg::ADDR_STATUS, 8'h01);
        chk({13'h0000, ser_out, tx_irq, rx_irq}, 16'h0004);
        for (int i = 0; i < 8; i++) begin
            async_run(i);
        end
        sync_run(8'h01, 2'h3);
        sync_run(8'h00, 2'h0);
        sync_run(8'hff, 2'h2);
        wr(usx_pkg::ADDR_MODE_TWO, 8'h00);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
